// >>> rtl/sbd_device.sv
// Device end: SPI status, error flags, rate select and data buffers.
// Assumes a classic Wishbone master on clk_i and a partner on the link.
// What this block does
// - Completed byte sets receive-full, may interrupt
// - Data read or reset clears receive-full
// - Error enable gates overflow and fault interrupts
// - Overflow keeps old byte, drops new
// - Overflow clears by status then data read
// - Slave fault: select rises mid transfer
// - Master fault: select low any time
// - Fault clears by status read, control write
// - Buffer-to-shifter handoff sets transmit-empty
// - Idle shifter loads within two cycles
// - Active slave defers shifter load
// - Reset asserts transmit-empty
// - Software writes data only when empty
// - Fault enable permits flag, keeps set flag
// - Master without detection ignores select
// - Slave detection off only suppresses flag
// - Rate code picks divisor 2/8/32/128
// - Serial clock is base over twice divisor
// - Data write loads transmit, read returns receive
// - Software avoids read-modify-write on data
// - Receive interrupt enable gates receive-full
module sbd_device
  import sbd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   irq_o,
  sbd_link_if.device             link
);
  typedef enum logic [1:0] {SBD_IDLE, SBD_SHIFT, SBD_DONE} sbd_state_e;
  sbd_state_e state_q;

  logic [7:0] ctl_q, tx_buf_q, rx_buf_q, sh_q;
  logic       rxf_q, ovr_q, mode_fault_flag_q, txe_q, error_irq_enable_q, fden_q;
  logic [1:0] rate_q;
  logic       ovr_seen_q, mode_fault_flag_seen_q;
  logic       ss_prev_q, sck_prev_q, sck_o_q, sck_o_d, samp_q;
  logic [7:0] sh_d;
  logic [3:0] cnt_q;
  logic [7:0] div_q;
  logic [7:0] half_lim;
  logic       req, wr, rd, rd_st, rd_dat, wr_dat, wr_ctl, wr_st;
  logic       master, enabled, ss_n, sck_in, rx_bit;
  logic       load, byte_done, slave_sel, sck_rise, sck_fall, tick, shift_en;

  assign req    = cyc_i & stb_i & ~ack_o;
  assign wr     = req & we_i & sel_i[0];
  assign rd     = req & ~we_i;
  assign rd_st  = rd & (adr_i == ADDR_STATUS);
  assign rd_dat = rd & (adr_i == ADDR_DATA);
  assign wr_dat = wr & (adr_i == ADDR_DATA);
  assign wr_ctl = wr & (adr_i == ADDR_CONTROL);
  assign wr_st  = wr & (adr_i == ADDR_STATUS);

  assign master  = ctl_q[CTL_MASTER];
  assign enabled = ctl_q[CTL_ENABLE];

  // ----------------------------------------------------------------
  // Link inputs come from partner logic on clk_i, so they are used directly.
  // ----------------------------------------------------------------
  assign ss_n   = link.ss_n;
  assign sck_in = link.sck_p;
  assign rx_bit = master ? link.miso_p : link.mosi_p;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      ss_prev_q  <= ss_n;
      sck_prev_q <= sck_in;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one-cycle ack, unmapped reads return zero.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (rd) begin
        unique case (adr_i)
          ADDR_CONTROL: dat_o[7:0] <= ctl_q;
          ADDR_STATUS:  dat_o[7:0] <= {rxf_q, error_irq_enable_q, ovr_q, mode_fault_flag_q, txe_q, fden_q, rate_q};
          ADDR_DATA:    dat_o[7:0] <= rx_buf_q;
          default:      dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= dat_i[7:0];
    end
  end

  // Only the writable status bits are taken; flags are left alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_irq_enable_q <= 1'b0;
      fden_q  <= 1'b0;
      rate_q  <= 2'b00;
    end else if (wr_st) begin
      error_irq_enable_q <= dat_i[ST_ERROR_IRQ_ENABLE];
      fden_q  <= dat_i[ST_FDEN];
      rate_q  <= dat_i[ST_RATEH:ST_RATEL];
    end
  end

  // ----------------------------------------------------------------
  // Master rate: the bus clock stands for the base clock output.
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rate_q)
      2'b00: half_lim = HALF_W'(DIV_00);
      2'b01: half_lim = HALF_W'(DIV_01);
      2'b10: half_lim = HALF_W'(DIV_10);
      2'b11: half_lim = HALF_W'(DIV_11);
    endcase
  end

  // Toggling every divisor cycles gives base / (2 * divisor).
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != SBD_SHIFT || !master) begin
      div_q <= 8'h00;
    end else if (div_q == half_lim - 8'h01) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = master && state_q == SBD_SHIFT && div_q == half_lim - 8'h01;

  // ----------------------------------------------------------------
  // Shifter: data is sampled on the rising edge, shifted on the falling.
  // ----------------------------------------------------------------
  assign slave_sel = ~master & ~ss_n;
  assign sck_rise  = master ? (tick & ~sck_o_q) : (slave_sel & sck_in & ~sck_prev_q);
  assign sck_fall  = master ? (tick & sck_o_q)  : (slave_sel & ~sck_in & sck_prev_q);
  assign load      = enabled && !txe_q && state_q == SBD_IDLE;
  assign shift_en  = sck_fall && state_q == SBD_SHIFT;
  assign byte_done = shift_en && cnt_q == BIT_LAST - 4'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i || !enabled) begin
      state_q <= SBD_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        SBD_IDLE: if (load && master) begin
          state_q <= SBD_SHIFT;
          cnt_q   <= 4'h0;
        end else if (!master && sck_rise) begin
          state_q <= SBD_SHIFT;
        end
        SBD_SHIFT: begin
          if (shift_en) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_done) begin
            state_q <= SBD_DONE;
          end
        end
        SBD_DONE: begin
          state_q <= SBD_IDLE;
          cnt_q   <= 4'h0;
        end
      endcase
    end
  end

  // Next clock and shifter values, so the pins move in the cycle the state does.
  always_comb begin
    sck_o_d = sck_o_q;
    if (!enabled) begin
      sck_o_d = 1'b0;
    end else if (tick) begin
      sck_o_d = ~sck_o_q;
    end
    sh_d = sh_q;
    if (load) begin
      sh_d = tx_buf_q;
    end else if (shift_en) begin
      sh_d = {sh_q[6:0], samp_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o_q <= 1'b0;
      sh_q    <= 8'h00;
      samp_q  <= 1'b0;
    end else begin
      sck_o_q <= sck_o_d;
      sh_q    <= sh_d;
      if (sck_rise) begin
        samp_q <= rx_bit;
      end
    end
  end

  // Data buffers have no reset branch.
  always_ff @(posedge clk_i) begin
    if (wr_dat) begin
      tx_buf_q <= dat_i[7:0];
    end
    if (byte_done && !rxf_q) begin
      rx_buf_q <= {sh_q[6:0], samp_q};
    end
  end

  // ----------------------------------------------------------------
  // Flags: a hardware set wins over a clear in the same cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txe_q <= 1'b1;
    end else if (load) begin
      txe_q <= 1'b1;
    end else if (wr_dat) begin
      txe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxf_q <= 1'b0;
    end else if (byte_done) begin
      rxf_q <= 1'b1;
    end else if (rd_dat) begin
      rxf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_q      <= 1'b0;
      ovr_seen_q <= 1'b0;
    end else if (byte_done && rxf_q) begin
      ovr_q      <= 1'b1;
      ovr_seen_q <= 1'b0;
    end else if (rd_st && ovr_q) begin
      ovr_seen_q <= 1'b1;
    end else if (rd_dat && ovr_seen_q) begin
      ovr_q      <= 1'b0;
      ovr_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_fault_flag_q      <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
    end else if (enabled && fden_q && ((!master && state_q == SBD_SHIFT && ss_n && !ss_prev_q)
                 || (master && !ss_n))) begin
      mode_fault_flag_q      <= 1'b1;
      mode_fault_flag_seen_q <= 1'b0;
    end else if (rd_st && mode_fault_flag_q) begin
      mode_fault_flag_seen_q <= 1'b1;
    end else if (wr_ctl && mode_fault_flag_seen_q) begin
      mode_fault_flag_q      <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o          <= 1'b0;
      link.sck_m     <= 1'b0;
      link.mosi_m    <= 1'b0;
      link.miso_s    <= 1'b0;
      link.miso_s_oe <= 1'b0;
    end else begin
      irq_o <= (rxf_q & ctl_q[CTL_RX_IE]) | (txe_q & ctl_q[CTL_TX_IE])
             | (error_irq_enable_q & (ovr_q | mode_fault_flag_q));
      link.sck_m     <= enabled & master & sck_o_d;
      link.mosi_m    <= sh_d[7];
      link.miso_s    <= sh_d[7];
      link.miso_s_oe <= enabled & slave_sel;
    end
  end
endmodule : sbd_device

// >>> pkg/sbd_pkg.sv
// Shared constants for the serial status, baud and data block.
// Assumes a 100 MHz bus clock and 8-bit SPI characters.
package sbd_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;

  // Register indexes; byte address is four times the index.
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_STATUS  = 8'h11;
  localparam logic [7:0] IDX_DATA    = 8'h12;
  localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_DATA    = {IDX_DATA, 2'b00};
  localparam int unsigned ADDR_W = 10;

  // Control register fields.
  localparam int unsigned CTL_RX_IE  = 7;
  localparam int unsigned CTL_MASTER = 5;
  localparam int unsigned CTL_ENABLE = 1;
  localparam int unsigned CTL_TX_IE  = 0;
  localparam logic [7:0]  CTL_RESET  = 8'h20;

  // Status/control register fields.
  localparam int unsigned ST_RXF   = 7;
  localparam int unsigned ST_ERROR_IRQ_ENABLE = 6;
  localparam int unsigned ST_OVR   = 5;
  localparam int unsigned ST_MODE_FAULT_FLAG  = 4;
  localparam int unsigned ST_TXE   = 3;
  localparam int unsigned ST_FDEN  = 2;
  localparam int unsigned ST_RATEH = 1;
  localparam int unsigned ST_RATEL = 0;
  localparam logic [7:0]  ST_WR_MASK = 8'h47;

  // Master rate divisors for codes 00, 01, 10, 11.
  localparam int unsigned DIV_00 = 2;
  localparam int unsigned DIV_01 = 8;
  localparam int unsigned DIV_10 = 32;
  localparam int unsigned DIV_11 = 128;
  localparam int unsigned HALF_W = 8;
  localparam int unsigned BITS   = 8;
  localparam logic [3:0]  BIT_LAST = 4'h8;
endpackage : sbd_pkg

// >>> pkg/sbd_link_if.sv
// Serial link between the device end and the partner end.
// Assumes both ends run on the same bus clock; no open-drain wiring.
interface sbd_link_if;
  logic sck_m;     // Clock driven by the device when master.
  logic mosi_m;    // Data out of the device when master.
  logic miso_s;    // Data out of the device when slave.
  logic miso_s_oe; // Device drives its slave output.
  logic sck_p;     // Clock driven by the partner when it is master.
  logic mosi_p;    // Data driven by the partner when it is master.
  logic miso_p;    // Data returned by the partner when it is slave.
  logic ss_n;      // Select from the partner to the device, active low.
  modport device (
    output sck_m, mosi_m, miso_s, miso_s_oe,
    input  sck_p, mosi_p, miso_p, ss_n
  );
  modport partner (
    input  sck_m, mosi_m, miso_s, miso_s_oe,
    output sck_p, mosi_p, miso_p, ss_n
  );
endinterface : sbd_link_if

// >>> rtl/sbd_partner.sv
// Partner end: a plain SPI peer that is master or slave on request.
// Assumes the device end shares clk_i, so link inputs are used directly.
// Sampling is on the rising clock edge; data shifts on the falling edge.
module sbd_partner
  import sbd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       act_master_i,
  input  wire logic       start_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       ss_n_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rx_byte_o,
  sbd_link_if.partner     link
);
  logic       sck_prev_q, ss_q, sck_q, busy_q, done_q, samp_q;
  logic [7:0] sh_q, rx_q;
  logic [3:0] cnt_q;
  logic [3:0] div_q;
  logic       in_sck, in_data, rise, fall;

  assign in_sck  = link.sck_m;
  assign in_data = act_master_i ? link.miso_s : link.mosi_m;
  assign rise    = act_master_i ? (busy_q && div_q == 4'hF && !sck_q)
                                : (in_sck && !sck_prev_q);
  assign fall    = act_master_i ? (busy_q && div_q == 4'hF && sck_q)
                                : (!in_sck && sck_prev_q);

  // ----------------------------------------------------------------
  // Shifter: sample on the rising edge, shift out on the falling edge.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_q <= 1'b0;
      sck_q      <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      samp_q     <= 1'b0;
      sh_q       <= 8'h00;
      rx_q       <= 8'h00;
      cnt_q      <= 4'h0;
      div_q      <= 4'h0;
      ss_q       <= 1'b1;
    end else begin
      done_q     <= 1'b0;
      sck_prev_q <= in_sck;
      ss_q       <= ss_n_i;
      if (rise) begin
        samp_q <= in_data;
      end
      if (act_master_i) begin
        if (!busy_q && start_i) begin
          busy_q <= 1'b1;
          sh_q   <= tx_byte_i;
          cnt_q  <= 4'h0;
          div_q  <= 4'h0;
        end else if (busy_q) begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'hF) begin
            sck_q <= ~sck_q;
          end
        end
      end else begin
        if (!busy_q && start_i) begin
          sh_q <= tx_byte_i;
        end
        if (rise) begin
          busy_q <= 1'b1;
        end
      end
      if (fall) begin
        sh_q  <= {sh_q[6:0], samp_q};
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == BIT_LAST - 4'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          cnt_q  <= 4'h0;
          rx_q   <= {sh_q[6:0], samp_q};
        end
      end
    end
  end

  assign link.sck_p  = act_master_i & sck_q;
  assign link.mosi_p = sh_q[7];
  assign link.miso_p = sh_q[7];
  assign link.ss_n   = ss_q;

  assign busy_o    = busy_q;
  assign done_o    = done_q;
  assign rx_byte_o = rx_q;
endmodule : sbd_partner

// >>> verification/sbd_properties.sv
// Concurrent checks on the serial link that joins the two ends.
// Assumes one bus clock; the bench instantiates this beside the link.
module sbd_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_m,
  input wire logic mosi_m,
  input wire logic miso_s,
  input wire logic miso_s_oe,
  input wire logic sck_p,
  input wire logic mosi_p,
  input wire logic miso_p,
  input wire logic ss_n
);
  // ------
  // Helper logic.
  // ------
  logic [7:0] hi_cnt_q;

  // Counts the bus cycles that the master clock has stood high.
  always_ff @(posedge clk_i) begin
    if (rst_i) hi_cnt_q <= 8'h00;
    else if (sck_m) hi_cnt_q <= hi_cnt_q + 8'h01;
    else hi_cnt_q <= 8'h00;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------
  // Assertions.
  // ------
  a_sck_high_width: assert property (
    $fell(sck_m) |-> hi_cnt_q inside {8'h02, 8'h08, 8'h20, 8'h80})
    else $error("master clock high phase is not a legal divisor");
  a_sck_high_bound: assert property (
    sck_m |-> hi_cnt_q < 8'h80)
    else $error("master clock high phase too long");
  a_mosi_settled: assert property (
    $rose(sck_m) |-> $stable(mosi_m))
    else $error("master data moved at the sampling edge");
  a_partner_mosi_settled: assert property (
    $rose(sck_p) |-> $stable(mosi_p))
    else $error("partner data moved at the sampling edge");
  a_oe_follows_select: assert property (
    ss_n && $past(ss_n) && $past(ss_n, 2) && $past(ss_n, 3) && $past(ss_n, 4)
    |-> !miso_s_oe)
    else $error("slave output driven while not selected");
  a_oe_needs_select: assert property (
    $rose(miso_s_oe) |-> !ss_n && !$past(ss_n))
    else $error("slave output enabled without a low select");
  a_oe_excludes_master: assert property (
    miso_s_oe |-> !sck_m)
    else $error("slave output and master clock active together");
  a_idle_after_reset: assert property (
    $fell(rst_i) |-> !sck_m && !mosi_m && !miso_s_oe && ss_n)
    else $error("link not idle after reset");

  cover property ($fell(sck_m));
  cover property ($rose(miso_s_oe));
  cover property ($fell(sck_p));
endmodule // sbd_properties

// >>> verification/spi_status_baud_data_tb_top.sv
// Testbench joining the device end and the partner end over the link.
// Assumes a classic Wishbone master of its own and a 100 MHz clock.
module spi_status_baud_data_tb_top
  import sbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0]       wdat = 32'h00000000;
  logic              we = 1'b0;
  logic [3:0]        sel = 4'hF;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic [31:0]       rdat;
  logic              ack;
  logic              irq;
  logic              act_master = 1'b0;
  logic              start = 1'b0;
  logic [7:0]        ptx = 8'h00;
  logic              ss_n_i = 1'b1;
  logic              busy;
  logic              done;
  logic [7:0]        prx;
  logic [7:0]        q;
  int                fail_count = 0;
  int                num_checks = 0;
  int                n;
  localparam int unsigned DIVS [4] = '{DIV_00, DIV_01, DIV_10, DIV_11};

  initial forever #5 clk_i = ~clk_i;

  sbd_link_if sbd_link_if_inst ();
  sbd_device sbd_device_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
    .irq_o(irq), .link(sbd_link_if_inst));
  sbd_partner sbd_partner_inst (.clk_i(clk_i), .rst_i(rst_i), .act_master_i(act_master),
    .start_i(start), .tx_byte_i(ptx), .ss_n_i(ss_n_i), .busy_o(busy), .done_o(done),
    .rx_byte_o(prx), .link(sbd_link_if_inst));
  sbd_properties sbd_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sck_m(sbd_link_if_inst.sck_m), .mosi_m(sbd_link_if_inst.mosi_m),
    .miso_s(sbd_link_if_inst.miso_s), .miso_s_oe(sbd_link_if_inst.miso_s_oe),
    .sck_p(sbd_link_if_inst.sck_p), .mosi_p(sbd_link_if_inst.mosi_p),
    .miso_p(sbd_link_if_inst.miso_p), .ss_n(sbd_link_if_inst.ss_n));

  // ------
  // Bus and comparison tasks.
  // ------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; read data lands in q at the acknowledging edge.
  task automatic wb(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    adr <= a;
    we <= w;
    wdat <= {24'h000000, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(q, e);
  endtask

  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      wb(ADDR_STATUS, 1'b0, 8'h00);
      k++;
    end while (q[b] !== 1'b1 && k < 4000);
  endtask

  task automatic pstart(input logic [7:0] p);
    ptx <= p;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask

  // ------
  // Main sequence.
  // ------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_STATUS, 8'h08);
    rd(ADDR_CONTROL, CTL_RESET);
    wb(ADDR_STATUS, 1'b1, 8'hFF);
    rd(ADDR_STATUS, 8'h4F);
    wb(ADDR_CONTROL, 1'b1, 8'h21);
    chk({7'h00, irq}, 8'h01);
    wb(ADDR_CONTROL, 1'b1, 8'h22);
    chk({7'h00, irq}, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wb(ADDR_STATUS, 1'b1, 8'(r));
      pstart(8'hA0 + 8'(r));
      wb(ADDR_DATA, 1'b1, 8'h5A ^ 8'(r));
      rd(ADDR_STATUS, 8'h08 | 8'(r));
      n = 0;
      while (sbd_link_if_inst.sck_m === 1'b1 && n < 300) begin @(posedge clk_i); n++; end
      while (sbd_link_if_inst.sck_m !== 1'b1 && n < 900) begin @(posedge clk_i); n++; end
      n = 0;
      while (sbd_link_if_inst.sck_m === 1'b1 && n < 300) begin @(posedge clk_i); n++; end
      chk(8'(n), 8'(DIVS[r]));
      poll(ST_RXF);
      chk(q, 8'h88 | 8'(r));
      rd(ADDR_DATA, 8'hA0 + 8'(r));
      rd(ADDR_STATUS, 8'h08 | 8'(r));
      chk(prx, 8'h5A ^ 8'(r));
    end
    wb(ADDR_STATUS, 1'b1, 8'h00);
    wb(ADDR_CONTROL, 1'b1, 8'hA2);
    pstart(8'h11);
    wb(ADDR_DATA, 1'b1, 8'h01);
    poll(ST_RXF);
    chk({7'h00, irq}, 8'h01);
    pstart(8'h22);
    wb(ADDR_DATA, 1'b1, 8'h02);
    poll(ST_OVR);
    chk(q, 8'hA8);
    rd(ADDR_DATA, 8'h11);
    rd(ADDR_STATUS, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wb(ADDR_CONTROL, 1'b1, 8'h22);
    ss_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd(ADDR_STATUS, 8'h08);
    ss_n_i <= 1'b1;
    wb(ADDR_STATUS, 1'b1, 8'h04);
    ss_n_i <= 1'b0;
    poll(ST_MODE_FAULT_FLAG);
    chk(q, 8'h1C);
    chk({7'h00, irq}, 8'h00);
    wb(ADDR_STATUS, 1'b1, 8'h40);
    rd(ADDR_STATUS, 8'h58);
    chk({7'h00, irq}, 8'h01);
    ss_n_i <= 1'b1;
    wb(ADDR_CONTROL, 1'b1, 8'h22);
    rd(ADDR_STATUS, 8'h48);
    chk({7'h00, irq}, 8'h00);
    wb(ADDR_STATUS, 1'b1, 8'h00);
    wb(ADDR_CONTROL, 1'b1, 8'h02);
    act_master <= 1'b1;
    ss_n_i <= 1'b0;
    wb(ADDR_DATA, 1'b1, 8'hC3);
    pstart(8'h3C);
    poll(ST_RXF);
    rd(ADDR_DATA, 8'h3C);
    chk(prx, 8'hC3);
    wb(ADDR_STATUS, 1'b1, 8'h04);
    wb(ADDR_DATA, 1'b1, 8'h77);
    pstart(8'h55);
    n = 0;
    while (sbd_link_if_inst.sck_p !== 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
    ss_n_i <= 1'b1;
    poll(ST_MODE_FAULT_FLAG);
    chk(q, 8'h1C);
    wb(ADDR_CONTROL, 1'b1, 8'h02);
    rd(ADDR_STATUS, 8'h0C);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_DATA, 8'h3C);
    rd(ADDR_STATUS, 8'h08);
    rd(ADDR_CONTROL, CTL_RESET);
    give_verdict();
  end

  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
endmodule // spi_status_baud_data_tb_top
